// File: rtl/rsc_top.sv
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
module rsc_top
  import rsc_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_LEN = POWER_UP_DELAY_TIMER_CYCLES,
  parameter int OST_LEN  = OST_CYCLES,
  parameter int WDT_LEN  = WDT_TICKS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [15:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        external_reset_pin_n,
  input  wire logic        brownout_event,
  input  wire logic        parity_error_event,
  input  wire logic        wdt_osc_tick,
  input  wire logic        wdt_clear,
  input  wire logic        sleep_req,
  input  wire logic        irq_wake,
  input  wire logic        prog_mode,
  output logic             core_reset,
  output logic             sleeping,
  output logic             irq
);
  // ****************************************
  // State
  // ****************************************
  rsc_state_e         state,    next_state;
  logic [31:0]        cnt,      next_cnt;
  logic [31:0]        wdt_cnt,  next_wdt_cnt;
  logic [2:0]         status,   next_status;
  logic [13:0]        cfg,      next_cfg;
  logic [IRQ_W-1:0]   irq_stat, next_irq_stat;
  logic [IRQ_W-1:0]   irq_mask, next_irq_mask;
  logic               dp_we,    next_dp_we;
  logic [15:0]        dp_idx,   next_dp_idx;
  logic [31:0]        next_hrdata;
  logic               next_core_reset;
  logic               next_sleeping;
  logic               next_irq;
  logic               addr_ok;
  logic [15:0]        a_idx;
  logic               wdt_to;
  logic               bor_hit;
  logic [IRQ_W-1:0]   ev;

  // Start-up path after any reset other than power-up or brown-out
  function automatic rsc_state_e after_reset(input logic [13:0] c);
    if (c[1:0] == OSC_RC) begin
      return S_RUN;
    end
    return S_OST;
  endfunction : after_reset

  // Start-up path after power-up or brown-out
  function automatic rsc_state_e after_power(input logic [13:0] c);
    // Only power-up and brown-out reach the timer
    if (c[CFG_POWER_UP_DELAY_TIMER]) begin
      return S_POWER_UP_DELAY_TIMER;
    end
    return S_HOLD;
  endfunction : after_power

  function automatic logic [31:0] load_for(input rsc_state_e s);
    case (s)
      S_POWER_UP_DELAY_TIMER:  return 32'(POWER_UP_DELAY_TIMER_LEN - 1);
      S_OST:   return 32'(OST_LEN - 1);
      default: return 32'h0;
    endcase
  endfunction : load_for

  // ****************************************
  // Next values
  // ****************************************
  always_comb begin
    a_idx          = haddr >> 2;
    addr_ok        = hsel && htrans[1] && hready;
    wdt_to         = cfg[CFG_WDT] && wdt_osc_tick && (wdt_cnt == 32'(WDT_LEN - 1));
    bor_hit        = brownout_event && cfg[CFG_BROWNOUT_DETECT_ENABLE_CFG];
    next_state     = state;
    next_cnt       = (cnt != 32'h0) ? cnt - 32'h1 : 32'h0;
    next_wdt_cnt   = wdt_cnt;
    next_status    = status;
    next_cfg       = cfg;
    next_irq_stat  = irq_stat;
    next_irq_mask  = irq_mask;
    next_dp_we     = addr_ok && hwrite;
    next_dp_idx    = a_idx;
    next_hrdata    = 32'h0;
    ev             = '0;
    // Register writes in data phase
    if (dp_we) begin
      case (dp_idx)
        IDX_STATUS:   next_status = hwdata[2:0];
        IDX_IRQ_MASK: next_irq_mask = hwdata[IRQ_W-1:0];
        default: begin
          if (dp_idx == IDX_CONFIG && prog_mode) begin
            next_cfg = hwdata[13:0];
          end
        end
      endcase
    end
    // Read data captured in address phase
    if (addr_ok && !hwrite) begin
      case (a_idx)
        IDX_STATUS: next_hrdata = {24'h0, cfg[CFG_PARITY], 4'h0, status};
        IDX_IRQ_STAT: begin
          next_hrdata   = {28'h0, irq_stat};
          next_irq_stat = '0;
        end
        IDX_IRQ_MASK: next_hrdata = {28'h0, irq_mask};
        default: begin
          if (a_idx == IDX_CONFIG && prog_mode) begin
            next_hrdata = {18'h0, cfg};
          end
        end
      endcase
    end
    // Watchdog counter
    if (!cfg[CFG_WDT] || wdt_clear || wdt_to || (state == S_RUN && sleep_req)) begin
      next_wdt_cnt = 32'h0;
    end else if (wdt_osc_tick) begin
      next_wdt_cnt = wdt_cnt + 32'h1;
    end
    // Reset sequencer, pin first
    case (state)
      S_POWER_UP_DELAY_TIMER, S_OST: begin
        if (cnt == 32'h0) begin
          next_state = (state == S_POWER_UP_DELAY_TIMER) ? after_reset(cfg) : S_RUN;
        end
      end
      S_RUN: begin
        if (sleep_req) begin
          next_state = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (wdt_to || irq_wake) begin
          next_state = S_RUN;
        end
      end
      S_HOLD: begin
        if (external_reset_pin_n) begin
          next_state = after_reset(cfg);
        end
      end
      default: next_state = after_power(cfg);
    endcase
    // Parity and awake-watchdog events pass one hold cycle; brown-out goes via after_power; a watchdog in sleep only wakes
    if (bor_hit) begin
      next_status[ST_BOR] = 1'b0;
      next_state          = after_power(cfg);
      ev[EV_BOR]          = 1'b1;
    end else if (parity_error_event) begin
      next_status[ST_PER] = 1'b0;
      next_state          = S_HOLD;
      ev[EV_PAR]          = 1'b1;
    end else if (wdt_to) begin
      ev[EV_WDT] = 1'b1;
      if (state != S_SLEEP) begin
        next_state = S_HOLD;
      end
    end
    if (!external_reset_pin_n) begin
      next_state = S_HOLD;
    end
    if (next_state != state) begin
      next_cnt = load_for(next_state);
    end
    if (next_state == S_RUN && state != S_RUN && state != S_SLEEP) begin
      ev[EV_READY] = 1'b1;
    end
    next_irq_stat   = next_irq_stat | ev;
    next_core_reset = !(next_state == S_RUN || next_state == S_SLEEP);
    next_sleeping   = next_state == S_SLEEP;
    next_irq        = |(next_irq_stat & next_irq_mask);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= S_POWER_UP_DELAY_TIMER;
      cnt        <= 32'(POWER_UP_DELAY_TIMER_LEN - 1);
      wdt_cnt    <= 32'h0;
      status     <= ST_RESET;
      cfg        <= CFG_RESET;
      irq_stat   <= '0;
      irq_mask   <= '0;
      dp_we      <= 1'b0;
      dp_idx     <= 16'h0;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      core_reset <= 1'b1;
      sleeping   <= 1'b0;
      irq        <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      wdt_cnt    <= next_wdt_cnt;
      status     <= next_status;
      cfg        <= next_cfg;
      irq_stat   <= next_irq_stat;
      irq_mask   <= next_irq_mask;
      dp_we      <= next_dp_we;
      dp_idx     <= next_dp_idx;
      hrdata     <= next_hrdata;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      core_reset <= next_core_reset;
      sleeping   <= next_sleeping;
      irq        <= next_irq;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence status_read_s;
    addr_ok && !hwrite && a_idx == IDX_STATUS;
  endsequence
  sequence ost_entry_s;
    state != S_OST ##1 state == S_OST;
  endsequence

  mirror_bit_a: assert property (status_read_s |=> hrdata[7] == $past(cfg[CFG_PARITY]) && hrdata[6:3] == 4'h0)
    else $error("status bit 7 does not mirror config");
  per_flag_a: assert property (parity_error_event && !bor_hit |=> !status[ST_PER] && core_reset)
    else $error("parity reset flag not marked");
  bor_clear_a: assert property (bor_hit |=> !status[ST_BOR])
    else $error("brown-out flag not cleared");
  bor_ignore_a: assert property (brownout_event && !cfg[CFG_BROWNOUT_DETECT_ENABLE_CFG] && state == S_RUN && !sleep_req
                                 && !parity_error_event && !wdt_to && external_reset_pin_n |=> state == S_RUN)
    else $error("disabled brown-out caused reset");
  wdt_count_a: assert property (cfg[CFG_WDT] && wdt_osc_tick && !wdt_clear && !wdt_to && state != S_RUN
                                |=> wdt_cnt == $past(wdt_cnt) + 32'h1)
    else $error("watchdog did not advance");
  ost_hold_a: assert property (ost_entry_s |-> core_reset ##1 (core_reset || !external_reset_pin_n
                               || state != S_RUN))
    else $error("start-up timer released too early");
  power_up_delay_timer_once_a: assert property (state == S_RUN && wdt_to && !bor_hit |=> state != S_POWER_UP_DELAY_TIMER)
    else $error("power-up timer after watchdog reset");
  sleep_wake_a: assert property (state == S_SLEEP && irq_wake && !bor_hit && !parity_error_event
                                 && external_reset_pin_n |=> state == S_RUN ##1 !sleeping)
    else $error("interrupt did not wake");
  cfg_lock_a: assert property (!prog_mode |=> $stable(cfg))
    else $error("config changed outside programming mode");

  sequence hold_exit_s;
    state == S_HOLD && external_reset_pin_n && !bor_hit && !parity_error_event && !wdt_to;
  endsequence
  sequence cfg_read_s;
    addr_ok && !hwrite && a_idx == IDX_CONFIG && prog_mode;
  endsequence
  sequence space_read_s;
    addr_ok && !hwrite && a_idx >= IDX_SPACE_LO && a_idx <= IDX_SPACE_HI && !prog_mode;
  endsequence

  por_flag_a: assert property (!(dp_we && dp_idx == IDX_STATUS)
                               |=> status[ST_POR] == $past(status[ST_POR]))
    else $error("power-on flag changed without a write");
  par_hold_a: assert property (parity_error_event && !bor_hit |=> state == S_HOLD && core_reset)
    else $error("parity error did not hold the core");
  xtal_start_a: assert property (hold_exit_s ##0 cfg[1:0] != OSC_RC |=> state == S_OST && core_reset)
    else $error("crystal start skipped the start-up timer");
  power_up_delay_timer_enable_a: assert property (bor_hit && cfg[CFG_POWER_UP_DELAY_TIMER] && external_reset_pin_n
                                  |=> state == S_POWER_UP_DELAY_TIMER && core_reset)
    else $error("power-up timer not started");
  sleep_entry_a: assert property (state == S_RUN && sleep_req && !bor_hit && !parity_error_event && !wdt_to
                                  && external_reset_pin_n |=> sleeping && wdt_cnt == 32'h0)
    else $error("sleep entry wrong");
  cfg_read_a: assert property (cfg_read_s |=> hrdata == {18'h0, $past(cfg)})
    else $error("config word read wrong");
  space_hide_a: assert property (space_read_s |=> hrdata == 32'h0)
    else $error("programming space visible");
  rc_start_a: assert property (hold_exit_s ##0 cfg[1:0] == OSC_RC |=> state == S_RUN && !core_reset)
    else $error("resistor-capacitor start waited");
  wdt_off_a: assert property (!cfg[CFG_WDT] |=> wdt_cnt == 32'h0)
    else $error("disabled watchdog counted");
endmodule : rsc_top

// File: rtl/rsc_pkg.sv
package rsc_pkg;
  // ****************************************
  // Register indices, byte address = 4 * index
  // ****************************************
  localparam logic [15:0] IDX_STATUS   = 16'h008e;
  localparam logic [15:0] IDX_CONFIG   = 16'h2007;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h0090;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0091;
  localparam logic [15:0] IDX_SPACE_LO = 16'h2000;
  localparam logic [15:0] IDX_SPACE_HI = 16'h3fff;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          ST_MIRROR  = 7;
  localparam int          ST_PER     = 2;
  localparam int          ST_POR     = 1;
  localparam int          ST_BOR     = 0;
  localparam logic [2:0]  ST_RESET   = 3'h4;
  localparam int          CFG_WDT    = 2;
  localparam int          CFG_POWER_UP_DELAY_TIMER   = 3;
  localparam int          CFG_CP     = 4;
  localparam int          CFG_BROWNOUT_DETECT_ENABLE_CFG  = 6;
  localparam int          CFG_PARITY = 7;
  localparam logic [13:0] CFG_RESET  = 14'h3fff;
  localparam logic [1:0]  OSC_RC     = 2'h3;
  localparam logic [1:0]  OSC_HS     = 2'h2;
  localparam logic [1:0]  OSC_XT     = 2'h1;
  localparam logic [1:0]  OSC_LP     = 2'h0;
  localparam int          IRQ_W      = 4;
  localparam int          EV_READY   = 0;
  localparam int          EV_WDT     = 1;
  localparam int          EV_BOR     = 2;
  localparam int          EV_PAR     = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_HZ      = 50_000_000;
  localparam int          POWER_UP_DELAY_TIMER_MS     = 72;
  localparam int          POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_MS * (CLK_HZ / 1000);
  localparam int          OST_CYCLES  = 1024;
  localparam int          WDT_TICKS   = 256;
  typedef enum logic [4:0] {
    S_POWER_UP_DELAY_TIMER  = 5'h01,
    S_OST   = 5'h02,
    S_RUN   = 5'h04,
    S_SLEEP = 5'h08,
    S_HOLD  = 5'h10
  } rsc_state_e;
endpackage : rsc_pkg

// File: tb/rsc_top_tb.sv
`timescale 1ns/100ps
module rsc_top_tb
  import rsc_pkg::*;
;
  // **********
  // Signals
  // **********
  localparam int PW = 20;
  localparam int OS = 8;
  localparam int WD = 8;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [15:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        pin_n, bor_ev, par_ev, tick, wclr, slp, wake, prog;
  logic        core_reset, sleeping, irq;
  int          n_fail, checked, n;
  assign hready = hreadyout;
  rsc_top #(.POWER_UP_DELAY_TIMER_LEN(PW), .OST_LEN(OS), .WDT_LEN(WD)) dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_reset_pin_n(pin_n), .brownout_event(bor_ev),
    .parity_error_event(par_ev), .wdt_osc_tick(tick), .wdt_clear(wclr), .sleep_req(slp),
    .irq_wake(wake), .prog_mode(prog), .core_reset(core_reset), .sleeping(sleeping), .irq(irq));
  // **********
  // Helpers
  // **********
  task stop_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // Address phase held until hready, then data phase held until hready
  task bus(input logic w, input logic [15:0] i, input logic [31:0] wd, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {i[13:0], 2'h0};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    d = hrdata;
  endtask : bus
  task wr(input logic [15:0] i, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, i, v, x);
  endtask : wr
  task rdc(input string nm, input logic [15:0] i, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, i, 32'h0, x);
    chk(nm, e, x);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rdc
  task cfg(input logic [13:0] v);
    prog <= 1'b1;
    wr(IDX_CONFIG, {18'h0, v});
    prog <= 1'b0;
  endtask : cfg
  // Cycles spent in core reset
  task run_len;
    n = 0;
    repeat (10) if (core_reset !== 1'b1) @(posedge clk);
    while (core_reset === 1'b1 && n < 300) begin
      n++;
      @(posedge clk);
    end
  endtask : run_len
  task ticks(input int k);
    repeat (k) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
    end
  endtask : ticks
  task slp_go;
    slp <= 1'b1;
    cyc(1);
    slp <= 1'b0;
    cyc(2);
  endtask : slp_go
  task bor_go;
    bor_ev <= 1'b1;
    cyc(1);
    bor_ev <= 1'b0;
    run_len;
  endtask : bor_go
  // **********
  // Tests
  // **********
  task t_por;
    rdc("status", IDX_STATUS, 32'h84);
    rdc("cfg hidden", IDX_CONFIG, 32'h0);
    rdc("space", IDX_SPACE_LO, 32'h0);
    prog <= 1'b1;
    rdc("cfg", IDX_CONFIG, {18'h0, CFG_RESET});
    prog <= 1'b0;
    rdc("unmapped", 16'h0010, 32'h0);
    wr(IDX_STATUS, 32'hff);
    rdc("status w", IDX_STATUS, 32'h87);
    $display("test por done");
  endtask : t_por
  task t_par;
    wr(IDX_IRQ_MASK, 32'h8);
    cyc(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    par_ev <= 1'b1;
    cyc(1);
    par_ev <= 1'b0;
    run_len;
    chk("irq", 32'h1, {31'h0, irq});
    rdc("status par", IDX_STATUS, 32'h83);
    rdc("irq stat", IDX_IRQ_STAT, 32'h9);
    cyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(IDX_STATUS, 32'hff);
    $display("test parity done");
  endtask : t_par
  task t_wdt;
    cfg(14'h3ffd);
    ticks(WD);
    run_len;
    chk("wdt reset", 32'h1, {31'h0, n >= OS});
    ticks(WD - 1);
    wclr <= 1'b1;
    cyc(1);
    wclr <= 1'b0;
    ticks(1);
    chk("wdt cleared", 32'h0, {31'h0, core_reset});
    cfg(14'h3ff9);
    wr(IDX_CONFIG, 32'h0);
    prog <= 1'b1;
    rdc("cfg locked", IDX_CONFIG, 32'h3ff9);
    prog <= 1'b0;
    ticks(WD * 2);
    chk("wdt off", 32'h0, {31'h0, core_reset});
    $display("test watchdog done");
  endtask : t_wdt
  task t_sleep;
    cfg(14'h3fff);
    slp_go;
    chk("sleep", 32'h1, {31'h0, sleeping});
    wake <= 1'b1;
    cyc(3);
    wake <= 1'b0;
    chk("wake irq", 32'h0, {31'h0, sleeping});
    slp_go;
    pin_n <= 1'b0;
    cyc(3);
    chk("pin hold", 32'h1, {31'h0, core_reset});
    pin_n <= 1'b1;
    run_len;
    chk("wake pin", 32'h0, {31'h0, sleeping});
    slp_go;
    ticks(WD);
    cyc(2);
    chk("wake wdt", 32'h0, {31'h0, sleeping | core_reset});
    $display("test sleep done");
  endtask : t_sleep
  task t_osc;
    for (int k = 0; k < 4; k++) begin
      cfg({12'hfff, k[1:0]});
      pin_n <= 1'b0;
      cyc(3);
      pin_n <= 1'b1;
      run_len;
      chk("start-up", {31'h0, k != 3}, {31'h0, n >= OS});
      chk("no power-up", 32'h1, {31'h0, n < PW});
    end
    $display("test osc done");
  endtask : t_osc
  task t_bor;
    cfg(14'h3fff);
    wr(IDX_STATUS, 32'hff);
    bor_go;
    chk("power-up", 32'h1, {31'h0, n >= PW});
    rdc("status bor", IDX_STATUS, 32'h86);
    cfg(14'h3ff7);
    bor_go;
    chk("power-up off", 32'h1, {31'h0, n < OS});
    cfg(14'h3f7f);
    rdc("mirror", IDX_STATUS, 32'h06);
    cfg(14'h3f3f);
    bor_ev <= 1'b1;
    cyc(1);
    bor_ev <= 1'b0;
    cyc(2);
    chk("bor disabled", 32'h0, {31'h0, core_reset});
    $display("test brownout done");
  endtask : t_bor
  // **********
  // Main
  // **********
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    n_fail++;
    stop_test;
  end
  initial begin
    {rst, pin_n} = 2'h3;
    {hsel, hwrite, bor_ev, par_ev, tick, wclr, slp, wake, prog} = 9'h0;
    haddr = 16'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_fail = 0;
    checked = 0;
    cyc(5);
    rst <= 1'b0;
    run_len;
    chk("por len", 32'h1, {31'h0, n >= PW});
    t_por;
    t_par;
    t_wdt;
    t_sleep;
    t_osc;
    t_bor;
    stop_test;
  end
endmodule : rsc_top_tb
